// ### hdl/ict_core.sv
// instruction sequencing and timing core
// Functional notes
// RULE1: every instruction cycle lasts exactly four system clocks
// RULE2: ordinary instructions finish in one instruction cycle
// RULE3: jump, call, return, interrupt return, table read take two cycles
// RULE4: writing program counter low jumps there and costs one extra cycle
// RULE5: conditional skip costs one cycle, two when it skips
// RULE6: oscillator 4 or 8 MHz fixed by a programming option only
// RULE7: logic operations set zero flag on a zero result
// RULE8: rotates move one bit; carry variants pass the bit through carry
// RULE9: return resumes right after the originating call
// RULE10: conditional branches test a byte or a bit, then skip or not
// RULE11: bit set and clear rewrite only the chosen bit
// RULE12: addition carries above 255, subtraction borrows below zero
// RULE13: increment and decrement change by one, to memory or accumulator
// RULE14: table read fetches fixed data from program memory
// RULE15: moves go register to accumulator, back, and immediate to accumulator
// RULE16: power-down instruction enters the low-power state
// RULE17: interrupt return sets global enable; plain return leaves it alone
// RULE18: otherwise program counter advances by one per instruction
module ict_core #(
  parameter int unsigned PC_W = ict_pkg::PC_W,
  parameter int unsigned STACK_DEPTH = ict_pkg::STACK_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic osc_sel_8mhz,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [ict_pkg::INSN_W-1:0] prog_data,
  input wire logic wake_req,
  output logic [7:0] acc,
  output logic flag_z,
  output logic flag_c,
  output logic global_irq_enable,
  output logic [7:0] table_data,
  output logic powered_down,
  output logic osc_is_8mhz,
  output logic cycle_start,
  output logic insn_done
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  ict_pkg::ict_state_t state_q;
  logic [1:0] slot_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [ict_pkg::INSN_W-1:0] insn_q;
  logic [7:0] acc_q;
  logic z_q;
  logic c_q;
  logic irq_en_q;
  logic [7:0] tbl_q;
  logic osc_q;
  logic osc_caught_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic wake_s1_q;
  logic wake_s2_q;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] res;
  logic to_acc;
  logic to_mem;
  logic z_we;
  logic z_new;
  logic c_we;
  logic c_new;
  logic skip;
  logic extra;
  logic [8:0] wide;
  logic [3:0] op;
  logic [1:0] sub;
  logic [2:0] bitsel;
  logic [7:0] maddr;
  logic [7:0] imm;
  logic last_slot;
  logic exec;

  assign op = insn_q[15:12];
  assign sub = insn_q[11:10];
  assign bitsel = insn_q[10:8];
  assign maddr = insn_q[7:0];
  assign imm = insn_q[7:0];
  assign last_slot = (slot_q == ict_pkg::SLOT_LAST);
  assign exec = last_slot && (state_q == ict_pkg::ICT_RUN);

  ict_data_ram #(
    .DATA_W(8),
    .DEPTH(256)
  ) u_ram (
    .clock(clock),
    .rd_addr(maddr),
    .rd_data(mem_rd),
    .wr_en(mem_we),
    .wr_addr(maddr),
    .wr_data(mem_wd)
  );

  // four system clocks per instruction cycle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slot_q <= 2'h0;
    end
    else if (state_q == ict_pkg::ICT_HALT)
    begin
      slot_q <= 2'h0;
    end
    else
    begin
      slot_q <= slot_q + 2'h1; // RULE1
    end
  end

  // wake input crosses from outside
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= wake_req;
      wake_s2_q <= wake_s1_q;
    end
  end

  // oscillator option caught once after reset release
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_q <= 1'b0;
      osc_caught_q <= 1'b0;
    end
    else if (!osc_caught_q)
    begin
      osc_q <= osc_sel_8mhz; // RULE6
      osc_caught_q <= 1'b1;
    end
  end

  // datapath of the executing instruction
  always_comb
  begin
    res = acc_q;
    wide = 9'h000;
    to_acc = 1'b0;
    to_mem = 1'b0;
    z_we = 1'b0;
    c_we = 1'b0;
    c_new = c_q;
    skip = 1'b0;
    case (op)
      ict_pkg::OP_LOAD_MEM:
      begin
        res = mem_rd; // RULE15
        to_acc = 1'b1;
      end
      ict_pkg::OP_STORE_MEM:
      begin
        res = acc_q; // RULE15
        to_mem = 1'b1;
      end
      ict_pkg::OP_LOAD_IMM:
      begin
        res = imm; // RULE15
        to_acc = 1'b1;
      end
      ict_pkg::OP_ADD:
      begin
        wide = {1'b0, acc_q} + {1'b0, mem_rd} + {8'h00, sub[0] & c_q};
        res = wide[7:0];
        c_new = wide[8]; // RULE12
        c_we = 1'b1;
        z_we = 1'b1;
        to_acc = !sub[1];
        to_mem = sub[1];
      end
      ict_pkg::OP_SUB:
      begin
        wide = {1'b0, acc_q} - {1'b0, mem_rd} - {8'h00, sub[0] & !c_q};
        res = wide[7:0];
        c_new = !wide[8]; // RULE12
        c_we = 1'b1;
        z_we = 1'b1;
        to_acc = !sub[1];
        to_mem = sub[1];
      end
      ict_pkg::OP_LOGIC:
      begin
        case (sub)
          ict_pkg::LG_AND: res = acc_q & mem_rd;
          ict_pkg::LG_OR: res = acc_q | mem_rd;
          ict_pkg::LG_XOR: res = acc_q ^ mem_rd;
          default: res = ~mem_rd;
        endcase
        z_we = 1'b1; // RULE7
        to_acc = !insn_q[9];
        to_mem = insn_q[9];
      end
      ict_pkg::OP_INCDEC:
      begin
        res = sub[0] ? (mem_rd - 8'h01) : (mem_rd + 8'h01); // RULE13
        z_we = 1'b1;
        to_acc = sub[1];
        to_mem = !sub[1];
      end
      ict_pkg::OP_ROT:
      begin
        case (sub)
          2'h0: res = {mem_rd[0], mem_rd[7:1]}; // RULE8
          2'h1: res = {mem_rd[6:0], mem_rd[7]};
          2'h2:
          begin
            res = {c_q, mem_rd[7:1]}; // RULE8
            c_new = mem_rd[0];
            c_we = 1'b1;
          end
          default:
          begin
            res = {mem_rd[6:0], c_q};
            c_new = mem_rd[7];
            c_we = 1'b1;
          end
        endcase
        to_acc = insn_q[9];
        to_mem = !insn_q[9];
      end
      ict_pkg::OP_BITSET:
      begin
        res = mem_rd | (8'h01 << bitsel); // RULE11
        to_mem = 1'b1;
      end
      ict_pkg::OP_BITCLR:
      begin
        res = mem_rd & ~(8'h01 << bitsel); // RULE11
        to_mem = 1'b1;
      end
      ict_pkg::OP_SKIP:
      begin
        res = mem_rd;
        case (insn_q[9:8])
          ict_pkg::SK_ZERO: skip = (mem_rd == 8'h00); // RULE10
          ict_pkg::SK_BITZ: skip = !mem_rd[insn_q[2:0]];
          ict_pkg::SK_BITNZ: skip = mem_rd[insn_q[2:0]];
          default: skip = 1'b0;
        endcase
      end
      default:
      begin
        res = acc_q;
      end
    endcase
    z_new = (res == 8'h00);
  end

  assign mem_we = exec && to_mem;
  assign mem_wd = res;

  // flow: extra cycle for branches, table reads, program counter low writes, taken skips
  always_comb
  begin
    pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1}; // RULE18
    extra = 1'b0;
    case (op)
      ict_pkg::OP_JUMP, ict_pkg::OP_CALL:
      begin
        pc_d = insn_q[PC_W-1:0]; // RULE3
        extra = 1'b1;
      end
      ict_pkg::OP_SUB_EXIT:
      begin
        pc_d = stack_q[sp_q - SP_W'(1)]; // RULE9
        extra = 1'b1;
      end
      ict_pkg::OP_TABRD:
      begin
        extra = 1'b1; // RULE3
      end
      ict_pkg::OP_SKIP:
      begin
        if (skip)
        begin
          pc_d = pc_q + {{(PC_W-2){1'b0}}, 2'h2}; // RULE5
          extra = 1'b1;
        end
      end
      default:
      begin
        if (to_mem && maddr == ict_pkg::PC_LOW_ADDR)
        begin
          pc_d = {pc_q[PC_W-1:8], res}; // RULE4
          extra = 1'b1;
        end
      end
    endcase
  end

  // sequencing state machine
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ict_pkg::ICT_FETCH;
    end
    else
    begin
      case (state_q)
        ict_pkg::ICT_FETCH:
        begin
          if (last_slot)
          begin
            state_q <= ict_pkg::ICT_RUN;
          end
        end
        ict_pkg::ICT_RUN:
        begin
          if (last_slot)
          begin
            if (op == ict_pkg::OP_HALT)
            begin
              state_q <= ict_pkg::ICT_HALT; // RULE16
            end
            else if (extra)
            begin
              state_q <= ict_pkg::ICT_EXTRA; // RULE3
            end
            else
            begin
              state_q <= ict_pkg::ICT_RUN; // RULE2
            end
          end
        end
        ict_pkg::ICT_EXTRA:
        begin
          if (last_slot)
          begin
            state_q <= ict_pkg::ICT_RUN;
          end
        end
        ict_pkg::ICT_HALT:
        begin
          if (wake_s2_q)
          begin
            state_q <= ict_pkg::ICT_FETCH;
          end
        end
        default:
        begin
          state_q <= ict_pkg::ICT_FETCH;
        end
      endcase
    end
  end

  // program counter and instruction register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_q <= ict_pkg::RESET_VECTOR;
      insn_q <= '0;
    end
    else if (last_slot)
    begin
      if (exec)
      begin
        pc_q <= pc_d; // RULE18
      end
      if (state_q != ict_pkg::ICT_RUN || !extra)
      begin
        insn_q <= prog_data;
      end
    end
  end

  // return stack
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_q[i] <= '0;
      end
    end
    else if (exec && op == ict_pkg::OP_CALL)
    begin
      stack_q[sp_q] <= pc_q + {{(PC_W-1){1'b0}}, 1'b1}; // RULE9
      sp_q <= sp_q + SP_W'(1);
    end
    else if (exec && op == ict_pkg::OP_SUB_EXIT)
    begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  // accumulator and flags
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q <= 8'h00;
      z_q <= 1'b0;
      c_q <= 1'b0;
    end
    else if (exec)
    begin
      if (to_acc)
      begin
        acc_q <= res;
      end
      if (z_we)
      begin
        z_q <= z_new; // RULE7
      end
      if (c_we)
      begin
        c_q <= c_new; // RULE12
      end
    end
  end

  // global enable on interrupt return
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_en_q <= 1'b0;
    end
    else if (exec && op == ict_pkg::OP_SUB_EXIT && insn_q[0])
    begin
      irq_en_q <= 1'b1; // RULE17
    end
  end

  // table byte caught one slot before the next fetch
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tbl_q <= 8'h00;
    end
    else if (state_q == ict_pkg::ICT_EXTRA && slot_q == 2'h2 && op == ict_pkg::OP_TABRD)
    begin
      tbl_q <= prog_data[7:0]; // RULE14
    end
  end

  always_comb
  begin
    if (state_q == ict_pkg::ICT_EXTRA && op == ict_pkg::OP_TABRD && !last_slot)
    begin
      prog_addr = {acc_q[PC_W-9:0], insn_q[7:0]}; // RULE14
    end
    else if (exec && !extra)
    begin
      prog_addr = pc_d; // RULE18
    end
    else
    begin
      prog_addr = pc_q;
    end
  end

  assign acc = acc_q;
  assign flag_z = z_q;
  assign flag_c = c_q;
  assign global_irq_enable = irq_en_q;
  assign table_data = tbl_q;
  assign powered_down = (state_q == ict_pkg::ICT_HALT);
  assign osc_is_8mhz = osc_q;
  assign cycle_start = (slot_q == 2'h0) && (state_q != ict_pkg::ICT_HALT);
  assign insn_done = last_slot && ((state_q == ict_pkg::ICT_EXTRA) || (exec && !extra));
endmodule

// ### hdl/ict_data_ram.sv
// data memory with registered read port
module ict_data_ram #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned DEPTH = 256
) (
  input wire logic clock,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### hdl/ict_pkg.sv
// constants for the instruction cycle timing core
package ict_pkg;
  localparam int unsigned PC_W = 11;
  localparam int unsigned INSN_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned STACK_DEPTH = 4;
  localparam int unsigned SLOTS_PER_CYCLE = 4;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [DATA_W-1:0] PC_LOW_ADDR = 8'h06;
  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned OSC_4MHZ = 4000000;
  localparam int unsigned OSC_8MHZ = 8000000;
  // opcode classes in insn[15:12]
  localparam logic [3:0] OP_LOAD_MEM = 4'h0;
  localparam logic [3:0] OP_STORE_MEM = 4'h1;
  localparam logic [3:0] OP_LOAD_IMM = 4'h2;
  localparam logic [3:0] OP_ADD = 4'h3;
  localparam logic [3:0] OP_SUB = 4'h4;
  localparam logic [3:0] OP_LOGIC = 4'h5;
  localparam logic [3:0] OP_INCDEC = 4'h6;
  localparam logic [3:0] OP_ROT = 4'h7;
  localparam logic [3:0] OP_BITSET = 4'h8;
  localparam logic [3:0] OP_BITCLR = 4'h9;
  localparam logic [3:0] OP_SKIP = 4'hA;
  localparam logic [3:0] OP_JUMP = 4'hB;
  localparam logic [3:0] OP_CALL = 4'hC;
  localparam logic [3:0] OP_SUB_EXIT = 4'hD;
  localparam logic [3:0] OP_TABRD = 4'hE;
  localparam logic [3:0] OP_HALT = 4'hF;
  // sub-field variants: LG_ in insn[11:10], SK_ in insn[9:8]
  localparam logic [1:0] LG_AND = 2'h0;
  localparam logic [1:0] LG_OR = 2'h1;
  localparam logic [1:0] LG_XOR = 2'h2;
  localparam logic [1:0] LG_INV = 2'h3;
  localparam logic [1:0] SK_ZERO = 2'h0;
  localparam logic [1:0] SK_BITZ = 2'h1;
  localparam logic [1:0] SK_BITNZ = 2'h2;
  typedef enum logic [3:0] {
    ICT_RUN = 4'b0001,
    ICT_EXTRA = 4'b0010,
    ICT_HALT = 4'b0100,
    ICT_FETCH = 4'b1000
  } ict_state_t;
endpackage

// ### verif/ict_core_bench.sv
// self-checking bench for the instruction cycle timing core
module ict_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] LDI = ict_pkg::OP_LOAD_IMM;
  localparam logic [3:0] STA = ict_pkg::OP_STORE_MEM;
  logic clock, reset_n, osc_sel_8mhz, wake_req;
  logic [ict_pkg::PC_W-1:0] prog_addr;
  logic [ict_pkg::INSN_W-1:0] prog_data;
  logic [7:0] acc, table_data;
  logic flag_z, flag_c, global_irq_enable, powered_down, osc_is_8mhz, cycle_start, insn_done;
  int mismatches = 0;
  int checked = 0;
  ict_core dut (
    .clock(clock),
    .reset_n(reset_n),
    .osc_sel_8mhz(osc_sel_8mhz),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .wake_req(wake_req),
    .acc(acc),
    .flag_z(flag_z),
    .flag_c(flag_c),
    .global_irq_enable(global_irq_enable),
    .table_data(table_data),
    .powered_down(powered_down),
    .osc_is_8mhz(osc_is_8mhz),
    .cycle_start(cycle_start),
    .insn_done(insn_done)
  );
  ict_prog_mem u_mem (
    .addr(prog_addr),
    .data(prog_data)
  );
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [15:0] w(input logic [3:0] c, input logic [3:0] m, input logic [7:0] b);
    return {c, m, b};
  endfunction
  task automatic summarize;
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input int base, input logic [15:0] ws[$]);
    for (int i = 0; i < 2048; i++)
      u_mem.mem[i] = w(LDI, 4'h0, 8'hEE);
    foreach (ws[i])
      u_mem.mem[base+i] = ws[i];
  endtask
  task automatic rst(input logic sel);
    #1 reset_n = 1'b0;
    osc_sel_8mhz = sel;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
  endtask
  task automatic step(input int n_exp, input logic [7:0] a_exp);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      #2;
      n++;
    end while (insn_done !== 1'b1 && n < 40);
    @(posedge clock);
    #2;
    n++;
    if (n_exp > 0)
      chk(8'(n), 8'(n_exp));
    chk(acc, a_exp);
  endtask
  task automatic scn_osc;
    load(0, '{w(LDI, 4'h0, 8'h01)});
    rst(1'b1);
    repeat (3) @(posedge clock);
    #1 osc_sel_8mhz = 1'b0;
    repeat (8) @(posedge clock);
    chk(8'(osc_is_8mhz), 8'h01);
    rst(1'b0);
    repeat (8) @(posedge clock);
    chk(8'(osc_is_8mhz), 8'h00);
  endtask
  task automatic scn_alu;
    load(0, '{w(LDI, 4'h0, 8'h80), w(STA, 4'h0, 8'h80), w(ict_pkg::OP_ADD, 4'h0, 8'h80),
      w(LDI, 4'h0, 8'h55), w(STA, 4'h0, 8'h55), w(ict_pkg::OP_LOGIC, 4'h8, 8'h55),
      w(LDI, 4'h0, 8'h20), w(STA, 4'h0, 8'h20), w(LDI, 4'h0, 8'h10),
      w(ict_pkg::OP_SUB, 4'h0, 8'h20)});
    rst(1'b0);
    step(0, 8'h80);
    step(4, 8'h80);
    step(4, 8'h00);
    chk(8'(flag_c), 8'h01);
    step(4, 8'h55);
    step(4, 8'h55);
    step(4, 8'h00);
    chk(8'(flag_z), 8'h01);
    step(4, 8'h20);
    step(4, 8'h20);
    step(4, 8'h10);
    step(4, 8'hF0);
    chk(8'(flag_c), 8'h00);
  endtask
  task automatic scn_flow;
    load(0, '{w(LDI, 4'h0, 8'h10), w(STA, 4'h0, 8'h06)});
    u_mem.mem[16] = w(ict_pkg::OP_CALL, 4'h1, 8'h00);
    u_mem.mem[17] = w(ict_pkg::OP_CALL, 4'h2, 8'h00);
    u_mem.mem[18] = w(LDI, 4'h0, 8'h01);
    u_mem.mem[19] = w(ict_pkg::OP_TABRD, 4'h0, 8'h40);
    u_mem.mem[20] = w(ict_pkg::OP_JUMP, 4'h0, 8'h30);
    u_mem.mem[48] = w(LDI, 4'h0, 8'h99);
    u_mem.mem[256] = w(LDI, 4'h0, 8'h3C);
    u_mem.mem[257] = w(ict_pkg::OP_SUB_EXIT, 4'h0, 8'h00);
    u_mem.mem[512] = w(ict_pkg::OP_SUB_EXIT, 4'h0, 8'h01);
    u_mem.mem[320] = 16'h00A5;
    rst(1'b0);
    step(0, 8'h10);
    step(8, 8'h10);
    step(8, 8'h10);
    step(4, 8'h3C);
    step(8, 8'h3C);
    chk(8'(global_irq_enable), 8'h00);
    step(8, 8'h3C);
    step(8, 8'h3C);
    chk(8'(global_irq_enable), 8'h01);
    step(4, 8'h01);
    step(8, 8'h01);
    chk(table_data, 8'hA5);
    step(8, 8'h01);
    step(4, 8'h99);
  endtask
  task automatic scn_skip_halt;
    load(0, '{w(LDI, 4'h0, 8'h00), w(STA, 4'h0, 8'h20), w(ict_pkg::OP_SKIP, 4'h0, 8'h20),
      w(LDI, 4'h0, 8'h11), w(LDI, 4'h0, 8'h22), w(STA, 4'h0, 8'h21),
      w(ict_pkg::OP_SKIP, 4'h0, 8'h21), w(LDI, 4'h0, 8'h33),
      w(ict_pkg::OP_HALT, 4'h0, 8'h00), w(LDI, 4'h0, 8'h44)});
    rst(1'b0);
    step(0, 8'h00);
    step(4, 8'h00);
    step(8, 8'h00);
    step(4, 8'h22);
    step(4, 8'h22);
    step(4, 8'h22);
    step(4, 8'h33);
    repeat (12) @(posedge clock);
    chk(8'(powered_down), 8'h01);
    #1 wake_req = 1'b1;
    step(0, 8'h44);
    #1 wake_req = 1'b0;
  endtask
  task automatic scn_bits;
    load(0, '{w(LDI, 4'h0, 8'h41), w(STA, 4'h0, 8'h30), w(ict_pkg::OP_ROT, 4'hA, 8'h30),
      w(ict_pkg::OP_ROT, 4'hE, 8'h30), w(ict_pkg::OP_ROT, 4'h0, 8'h30),
      w(ict_pkg::OP_INCDEC, 4'h8, 8'h30), w(ict_pkg::OP_ROT, 4'h6, 8'h30),
      w(ict_pkg::OP_BITSET, 4'h1, 8'h30), w(ict_pkg::OP_BITCLR, 4'h7, 8'h30),
      w(ict_pkg::OP_INCDEC, 4'h4, 8'h30), w(ict_pkg::OP_LOAD_MEM, 4'h0, 8'h30),
      w(ict_pkg::OP_INCDEC, 4'hC, 8'h30), w(ict_pkg::OP_SKIP, 4'h2, 8'h30),
      w(LDI, 4'h0, 8'h77), w(LDI, 4'h0, 8'h5A)});
    rst(1'b0);
    step(0, 8'h41);
    step(4, 8'h41);
    step(4, 8'h20);
    chk(8'(flag_c), 8'h01);
    step(4, 8'h83);
    chk(8'(flag_c), 8'h00);
    step(4, 8'h83);
    step(4, 8'hA1);
    step(4, 8'h41);
    step(4, 8'h41);
    step(4, 8'h41);
    step(4, 8'h41);
    step(4, 8'h21);
    step(4, 8'h20);
    step(8, 8'h20);
    step(4, 8'h5A);
  endtask
  initial
  begin
    reset_n = 1'b0;
    osc_sel_8mhz = 1'b0;
    wake_req = 1'b0;
    scn_osc;
    scn_alu;
    scn_flow;
    scn_skip_halt;
    scn_bits;
    summarize;
  end
  initial
  begin
    #300000;
    mismatches++;
    summarize;
  end
endmodule

// ### verif/ict_core_properties.sv
// assertions on the ports of the instruction cycle timing core
module ict_core_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wake_req,
  input wire logic [7:0] acc,
  input wire logic [7:0] table_data,
  input wire logic global_irq_enable,
  input wire logic powered_down,
  input wire logic osc_is_8mhz,
  input wire logic cycle_start,
  input wire logic insn_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_slot_gap;
    cycle_start |=> !cycle_start [*3];
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("cycle start spacing");
  property p_done_slot;
    insn_done |-> $past(cycle_start, 3);
  endproperty
  a_done_slot: assert property (p_done_slot) else $error("done off last slot");
  property p_done_gap;
    insn_done |=> !insn_done [*3];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("done spacing");
  property p_acc_done;
    $changed(acc) |-> $past(insn_done);
  endproperty
  a_acc_done: assert property (p_acc_done) else $error("acc moved off done");
  property p_osc_fixed;
    $past(reset_n, 2) |-> $stable(osc_is_8mhz);
  endproperty
  a_osc_fixed: assert property (p_osc_fixed) else $error("osc option moved");
  property p_halt_hold;
    powered_down && $past(powered_down) |-> $stable(acc);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("acc moved in halt");
  property p_wake;
    powered_down && wake_req |-> ##[1:6] !powered_down;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_table_done;
    $changed(table_data) |-> insn_done;
  endproperty
  a_table_done: assert property (p_table_done) else $error("table byte off done");
  property p_irq_done;
    $rose(global_irq_enable) |-> ##[0:4] insn_done;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("irq enable off done");
endmodule

bind ict_core ict_core_checker u_chk (
  .clock(clock),
  .reset_n(reset_n),
  .wake_req(wake_req),
  .acc(acc),
  .table_data(table_data),
  .global_irq_enable(global_irq_enable),
  .powered_down(powered_down),
  .osc_is_8mhz(osc_is_8mhz),
  .cycle_start(cycle_start),
  .insn_done(insn_done)
);

// ### verif/ict_prog_mem.sv
// program memory model answering fetches and table reads
module ict_prog_mem (
  input wire logic [ict_pkg::PC_W-1:0] addr,
  output logic [ict_pkg::INSN_W-1:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ict_pkg::INSN_W-1:0] mem [0:2047];
  assign data = mem[addr];
endmodule
